// >>> rtl/dccf_defs.vh
// Constants for the data cache coherency state machine.
// Assumes one core clock and a core that keeps the cache data arrays.
//
// How it works
// R1: Each 32-byte block holds exactly one state
// R2: Select bit 0 three-state, 1 four-state
// R3: Instruction cache keeps only valid or invalid
// R4: Three-state fills always use intent-to-modify reads (fetch fills still issue plain reads here)
// R5: Three-state fill leaves block exclusive, silent writes
// R6: Three-state snooped global read acts as write
// R7: Three-state single-beat snoop read keeps block
// R8: Software flushes and invalidates before four-state select
// R9: Four-state store to shared refetches same way
// R10: Clean gives shared four-state, exclusive three-state
// R11: Four-state load miss issues plain read
// R12: Four-state load touch reads, store touch modifies
// R13: Four-state fetch reads, global follows attributes
// R14: Load hit reads cache, no bus transaction
// R15: Load miss read: exclusive, shared, or retry
// R16: Store hit modified or exclusive ends modified, silent
// R17: Store to shared/invalid: modify-read, then modified
// R18: Fill picks victim way, casts out if modified
// R19: Push and flush copy back, kill discards
// R20: Coherent attribute drives global indicator on bus
// R21: Reset and flash invalidate clear every block
`ifndef DCCF_DEFS_VH
`define DCCF_DEFS_VH

// Block coherency states
`define DCCF_ST_I      2'h0
`define DCCF_ST_S      2'h1
`define DCCF_ST_E      2'h2
`define DCCF_ST_M      2'h3

// Bus transaction types
`define DCCF_BUS_READ  2'h0
`define DCCF_BUS_RDMOD 2'h1
`define DCCF_BUS_WB    2'h2

// Core request operations
`define DCCF_OP_LOAD   3'h0
`define DCCF_OP_STORE  3'h1
`define DCCF_OP_TLOAD  3'h2
`define DCCF_OP_TSTORE 3'h3
`define DCCF_OP_FETCH  3'h4
`define DCCF_OP_CLEAN  3'h5

// Snooped transaction types
`define DCCF_SNP_READ  3'h0
`define DCCF_SNP_READ1 3'h1
`define DCCF_SNP_RDMOD 3'h2
`define DCCF_SNP_KILL  3'h3
`define DCCF_SNP_CLEAN 3'h4

// Memory attribute bit position of the coherent bit (write-through and inhibit not defined)
`define DCCF_ATTR_M    0

// Machine states
`define DCCF_FSM_IDLE  2'h0
`define DCCF_FSM_CAST  2'h1
`define DCCF_FSM_FILL  2'h2
`define DCCF_FSM_WB    2'h3

`endif

// >>> rtl/dccf_core.v
// Data cache coherency state machine: tag and state arrays for a
// two-way data cache of eight sets, a small instruction valid table,
// bus transaction selection and snoop handling.
// Assumes the bus partner holds a snoop until o_snp_ready is high and
// pulses i_bus_ack or i_bus_retry once per issued transaction.
`timescale 1ns/1ps
`include "dccf_defs.vh"

module dccf_core (
   input  wire        i_ref_clk,
   input  wire        i_rst,
   input  wire        i_four_state_protocol_select,
   input  wire        i_flash_inv,
   input  wire        i_req_valid,
   input  wire [2:0]  i_req_op,
   input  wire [26:0] i_req_addr,
   input  wire [2:0]  i_req_mem_attr,
   input  wire        i_req_xlate_en,
   output wire        o_req_ready,
   output reg         o_done,
   output reg         o_done_hit,
   output reg  [1:0]  o_done_state,
   input  wire        i_snp_valid,
   input  wire [2:0]  i_snp_type,
   input  wire [26:0] i_snp_addr,
   output wire        o_snp_ready,
   output reg         o_snp_retry,
   output reg         o_bus_req,
   output reg  [1:0]  o_bus_type,
   output reg  [26:0] o_bus_addr,
   output reg         o_bus_glb,
   input  wire        i_bus_ack,
   input  wire        i_bus_retry,
   input  wire        i_bus_share
);

   // R1: one state per block, index is {set, way}
   reg  [1:0]  blk_state [0:15];
   reg  [23:0] blk_tag   [0:15];
   // Way to replace next, one bit per set
   reg  [7:0]  lru_reg;
   // Instruction cache valid table, direct mapped
   reg  [7:0]  ic_valid_reg;
   reg  [23:0] ic_tag    [0:7];

   reg  [1:0]  st_reg;
   reg  [2:0]  op_reg;
   reg  [2:0]  set_reg;
   reg  [23:0] tag_reg;
   reg         way_reg;
   reg  [1:0]  wb_next_reg;
   reg         snp_reg;
   reg         glb_reg;
   reg  [1:0]  fill_type_reg;
   integer     k;

   // R2: protocol select bit
   wire        mode4 = i_four_state_protocol_select;
   wire        idle  = (st_reg == `DCCF_FSM_IDLE);

   // Request lookup
   wire [2:0]  r_set = i_req_addr[2:0];
   wire [23:0] r_tag = i_req_addr[26:3];
   wire        r_h0  = (blk_state[{r_set, 1'b0}] != `DCCF_ST_I) &&
                       (blk_tag[{r_set, 1'b0}] == r_tag);
   wire        r_h1  = (blk_state[{r_set, 1'b1}] != `DCCF_ST_I) &&
                       (blk_tag[{r_set, 1'b1}] == r_tag);
   wire        r_hit = r_h0 | r_h1;
   wire        r_way = r_h1;
   wire [1:0]  r_st  = r_hit ? blk_state[{r_set, r_way}] : `DCCF_ST_I;
   wire        r_vic = lru_reg[r_set];
   wire [1:0]  v_st  = blk_state[{r_set, r_vic}];
   wire [23:0] v_tag = blk_tag[{r_set, r_vic}];
   wire        ic_hit = ic_valid_reg[r_set] && (ic_tag[r_set] == r_tag);

   // Snoop lookup
   wire [2:0]  s_set = i_snp_addr[2:0];
   wire [23:0] s_tag = i_snp_addr[26:3];
   wire        s_h0  = (blk_state[{s_set, 1'b0}] != `DCCF_ST_I) &&
                       (blk_tag[{s_set, 1'b0}] == s_tag);
   wire        s_h1  = (blk_state[{s_set, 1'b1}] != `DCCF_ST_I) &&
                       (blk_tag[{s_set, 1'b1}] == s_tag);
   wire        s_hit = s_h0 | s_h1;
   wire        s_way = s_h1;
   wire [1:0]  s_st  = s_hit ? blk_state[{s_set, s_way}] : `DCCF_ST_I;

   // R10: clean result
   wire [1:0]  clean_st = mode4 ? `DCCF_ST_S : `DCCF_ST_E;

   // Snoop result state and copy-back need
   reg  [1:0]  sn_next;
   reg         sn_wb;
   always @* begin
      sn_next = s_st;
      sn_wb   = 1'b0;
      case (i_snp_type)
         // R6: three-state read acts as write; R19: four-state push
         `DCCF_SNP_READ: begin
            sn_next = mode4 ? `DCCF_ST_S : `DCCF_ST_I;
            sn_wb   = (s_st == `DCCF_ST_M);
         end
         // R7: single-beat read keeps the block
         `DCCF_SNP_READ1: begin
            sn_next = mode4 ? `DCCF_ST_S :
                      ((s_st == `DCCF_ST_M) ? `DCCF_ST_E : s_st);
            sn_wb   = (s_st == `DCCF_ST_M);
         end
         // R19: flush copies back then invalidates
         `DCCF_SNP_RDMOD: begin
            sn_next = `DCCF_ST_I;
            sn_wb   = (s_st == `DCCF_ST_M);
         end
         // R19: kill discards with no copy-back
         `DCCF_SNP_KILL: begin
            sn_next = `DCCF_ST_I;
            sn_wb   = 1'b0;
         end
         // R10: snoop clean
         `DCCF_SNP_CLEAN: begin
            sn_next = clean_st;
            sn_wb   = (s_st == `DCCF_ST_M);
         end
         default: begin
            sn_next = s_st;
            sn_wb   = 1'b0;
         end
      endcase
   end

   // Fill transaction type per operation and protocol
   reg  [1:0]  fill_type;
   always @* begin
      case (i_req_op)
         // R11: four-state load miss reads; R4: three-state modifies
         `DCCF_OP_LOAD:   fill_type = mode4 ? `DCCF_BUS_READ : `DCCF_BUS_RDMOD;
         // R12: touch hints
         `DCCF_OP_TLOAD:  fill_type = mode4 ? `DCCF_BUS_READ : `DCCF_BUS_RDMOD;
         `DCCF_OP_TSTORE: fill_type = `DCCF_BUS_RDMOD;
         // R13: fetches read
         `DCCF_OP_FETCH:  fill_type = `DCCF_BUS_READ;
         default:         fill_type = `DCCF_BUS_RDMOD;
      endcase
   end

   // R20: global indicator; R13: four-state fetch global when untranslated
   reg         req_glb;
   always @* begin
      if (i_req_op == `DCCF_OP_FETCH)
         req_glb = mode4 ? (~i_req_xlate_en | i_req_mem_attr[`DCCF_ATTR_M])
                         : (i_req_xlate_en & i_req_mem_attr[`DCCF_ATTR_M]);
      else
         req_glb = i_req_mem_attr[`DCCF_ATTR_M];
   end

   // Handshakes: snoops take priority over core requests
   assign o_snp_ready = idle & ~i_flash_inv;
   assign o_req_ready = idle & ~i_flash_inv & ~i_snp_valid;

   // Fill result state on a clean completion
   wire [1:0]  fill_st =
      (op_reg == `DCCF_OP_STORE)  ? `DCCF_ST_M :
      (op_reg == `DCCF_OP_TSTORE) ? `DCCF_ST_E :
      (mode4 & i_bus_share)       ? `DCCF_ST_S : `DCCF_ST_E;

   // Main state machine and arrays
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         // R21: every block invalid after reset
         for (k = 0; k < 16; k = k + 1) begin
            blk_state[k] <= `DCCF_ST_I;
            blk_tag[k]   <= 24'h00_0000;
         end
         for (k = 0; k < 8; k = k + 1)
            ic_tag[k] <= 24'h00_0000;
         lru_reg       <= 8'h00;
         ic_valid_reg  <= 8'h00;
         st_reg        <= `DCCF_FSM_IDLE;
         op_reg        <= `DCCF_OP_LOAD;
         set_reg       <= 3'h0;
         tag_reg       <= 24'h00_0000;
         way_reg       <= 1'b0;
         wb_next_reg   <= `DCCF_ST_I;
         snp_reg       <= 1'b0;
         glb_reg       <= 1'b0;
         fill_type_reg <= `DCCF_BUS_READ;
         o_done        <= 1'b0;
         o_done_hit    <= 1'b0;
         o_done_state  <= `DCCF_ST_I;
         o_snp_retry   <= 1'b0;
         o_bus_req     <= 1'b0;
         o_bus_type    <= `DCCF_BUS_READ;
         o_bus_addr    <= 27'h000_0000;
         o_bus_glb     <= 1'b0;
      end else begin
         o_done      <= 1'b0;
         o_done_hit  <= 1'b0;
         o_snp_retry <= 1'b0;
         case (st_reg)
            `DCCF_FSM_IDLE: begin
               if (i_flash_inv) begin
                  // R21: flash invalidate clears both caches
                  for (k = 0; k < 16; k = k + 1)
                     blk_state[k] <= `DCCF_ST_I;
                  ic_valid_reg <= 8'h00;
               end else if (i_snp_valid) begin
                  if (s_hit) begin
                     set_reg <= s_set;
                     way_reg <= s_way;
                     if (sn_wb) begin
                        // R19: copy back modified block, retry snooper
                        o_snp_retry <= 1'b1;
                        snp_reg     <= 1'b1;
                        wb_next_reg <= sn_next;
                        o_bus_req   <= 1'b1;
                        o_bus_type  <= `DCCF_BUS_WB;
                        o_bus_addr  <= i_snp_addr;
                        o_bus_glb   <= 1'b0;
                        st_reg      <= `DCCF_FSM_WB;
                     end else begin
                        blk_state[{s_set, s_way}] <= sn_next;
                     end
                  end
               end else if (i_req_valid) begin
                  op_reg        <= i_req_op;
                  set_reg       <= r_set;
                  tag_reg       <= r_tag;
                  glb_reg       <= req_glb;
                  fill_type_reg <= fill_type;
                  snp_reg       <= 1'b0;
                  if (i_req_op == `DCCF_OP_FETCH) begin
                     // R3: instruction side is valid or invalid only
                     if (ic_hit) begin
                        o_done       <= 1'b1;
                        o_done_hit   <= 1'b1;
                        o_done_state <= `DCCF_ST_I;
                     end else begin
                        o_bus_req  <= 1'b1;
                        o_bus_type <= `DCCF_BUS_READ;
                        o_bus_addr <= i_req_addr;
                        o_bus_glb  <= req_glb;
                        st_reg     <= `DCCF_FSM_FILL;
                     end
                  end else if (i_req_op == `DCCF_OP_CLEAN) begin
                     if (r_st == `DCCF_ST_M) begin
                        // R10: write back then leave clean
                        way_reg     <= r_way;
                        wb_next_reg <= clean_st;
                        o_bus_req   <= 1'b1;
                        o_bus_type  <= `DCCF_BUS_WB;
                        o_bus_addr  <= i_req_addr;
                        o_bus_glb   <= req_glb;
                        st_reg      <= `DCCF_FSM_WB;
                     end else begin
                        if (r_hit)
                           blk_state[{r_set, r_way}] <= clean_st;
                        o_done       <= 1'b1;
                        o_done_hit   <= r_hit;
                        o_done_state <= r_hit ? clean_st : `DCCF_ST_I;
                     end
                  end else if (i_req_op == `DCCF_OP_STORE &&
                               r_st == `DCCF_ST_S) begin
                     // R9: store to shared refetches into the same way
                     way_reg       <= r_way;
                     fill_type_reg <= `DCCF_BUS_RDMOD;
                     blk_state[{r_set, r_way}] <= `DCCF_ST_I;
                     o_bus_req     <= 1'b1;
                     o_bus_type    <= `DCCF_BUS_RDMOD;
                     o_bus_addr    <= i_req_addr;
                     o_bus_glb     <= req_glb;
                     st_reg        <= `DCCF_FSM_FILL;
                  end else if (r_hit) begin
                     // R14: load hit; R16: store hit goes modified
                     lru_reg[r_set] <= ~r_way;
                     if (i_req_op == `DCCF_OP_STORE)
                        blk_state[{r_set, r_way}] <= `DCCF_ST_M;
                     o_done       <= 1'b1;
                     o_done_hit   <= 1'b1;
                     o_done_state <= (i_req_op == `DCCF_OP_STORE) ?
                                     `DCCF_ST_M : r_st;
                  end else begin
                     // R18: choose victim, cast out if modified
                     way_reg <= r_vic;
                     o_bus_req <= 1'b1;
                     if (v_st == `DCCF_ST_M) begin
                        o_bus_type <= `DCCF_BUS_WB;
                        o_bus_addr <= {v_tag, r_set};
                        o_bus_glb  <= 1'b0;
                        st_reg     <= `DCCF_FSM_CAST;
                     end else begin
                        blk_state[{r_set, r_vic}] <= `DCCF_ST_I;
                        o_bus_type <= fill_type;
                        o_bus_addr <= i_req_addr;
                        o_bus_glb  <= req_glb;
                        st_reg     <= `DCCF_FSM_FILL;
                     end
                  end
               end
            end
            `DCCF_FSM_CAST: begin
               // R18: retried cast-out stays up; done frees victim
               if (i_bus_ack && !i_bus_retry) begin
                  blk_state[{set_reg, way_reg}] <= `DCCF_ST_I;
                  o_bus_type <= fill_type_reg;
                  o_bus_addr <= {tag_reg, set_reg};
                  o_bus_glb  <= glb_reg;
                  st_reg     <= `DCCF_FSM_FILL;
               end
            end
            `DCCF_FSM_FILL: begin
               // R15 R17: retry keeps the request up and reissues it
               if (i_bus_ack && !i_bus_retry) begin
                  o_bus_req <= 1'b0;
                  o_done    <= 1'b1;
                  st_reg    <= `DCCF_FSM_IDLE;
                  if (op_reg == `DCCF_OP_FETCH) begin
                     ic_valid_reg[set_reg] <= 1'b1;
                     ic_tag[set_reg]       <= tag_reg;
                     o_done_state          <= `DCCF_ST_I;
                  end else begin
                     // R5 R15 R17: fill result state
                     blk_state[{set_reg, way_reg}] <= fill_st;
                     blk_tag[{set_reg, way_reg}]   <= tag_reg;
                     lru_reg[set_reg]              <= ~way_reg;
                     o_done_state                  <= fill_st;
                  end
               end
            end
            `DCCF_FSM_WB: begin
               // Copy-back done: apply the pending state
               if (i_bus_ack && !i_bus_retry) begin
                  blk_state[{set_reg, way_reg}] <= wb_next_reg;
                  o_bus_req    <= 1'b0;
                  o_done       <= ~snp_reg;
                  o_done_hit   <= ~snp_reg;
                  o_done_state <= wb_next_reg;
                  st_reg       <= `DCCF_FSM_IDLE;
               end
            end
            default: begin
               st_reg    <= `DCCF_FSM_IDLE;
               o_bus_req <= 1'b0;
            end
         endcase
      end
   end

endmodule // dccf_core

// >>> bench/dccf_monitor.sv
// Port checker for the data cache coherency state machine.
// Bound to dccf_core; sees its ports only, one clock domain.
`timescale 1ns/1ps
`include "dccf_defs.vh"

module dccf_monitor (
   input wire        i_ref_clk,
   input wire        i_rst,
   input wire        i_four_state_protocol_select,
   input wire        i_flash_inv,
   input wire        i_req_valid,
   input wire [2:0]  i_req_op,
   input wire [2:0]  i_req_mem_attr,
   input wire        i_snp_valid,
   input wire        i_bus_ack,
   input wire        i_bus_retry,
   input wire        o_req_ready,
   input wire        o_done,
   input wire        o_snp_retry,
   input wire        o_bus_req,
   input wire [1:0]  o_bus_type,
   input wire [26:0] o_bus_addr,
   input wire        o_bus_glb
);
   reg  [2:0] op_reg;
   reg        coh_reg;
   wire       take = i_req_valid && o_req_ready;

   // Kind and coherence attribute of the request in flight
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         op_reg  <= 3'h0;
         coh_reg <= 1'b0;
      end else if (take) begin
         op_reg  <= i_req_op;
         coh_reg <= i_req_mem_attr[`DCCF_ATTR_M];
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   AST_THREE_NO_READ: assert property (
      o_bus_req && !i_four_state_protocol_select && op_reg != `DCCF_OP_FETCH
      |-> o_bus_type != `DCCF_BUS_READ) else $error("read fill in three-state mode");
   AST_LOAD_PLAIN: assert property (
      take && i_four_state_protocol_select && i_req_op == `DCCF_OP_LOAD
      |=> !o_bus_req || o_bus_type != `DCCF_BUS_RDMOD) else $error("load miss not plain read");
   AST_HIT_OR_BUS: assert property (
      take && (i_req_op == `DCCF_OP_LOAD || i_req_op == `DCCF_OP_STORE)
      |=> o_done ^ o_bus_req) else $error("neither hit nor bus request");
   AST_HOLD_REQ: assert property (
      o_bus_req && (!i_bus_ack || i_bus_retry)
      |=> o_bus_req && $stable(o_bus_type) && $stable(o_bus_addr))
      else $error("bus request changed before its ack");
   AST_FILL_DONE: assert property (
      o_bus_req && i_bus_ack && !i_bus_retry && o_bus_type != `DCCF_BUS_WB
      |=> !o_bus_req && o_done) else $error("fill ack not followed by done");
   AST_SNOOP_PUSH: assert property (
      o_snp_retry |-> o_bus_req && o_bus_type == `DCCF_BUS_WB && !o_bus_glb)
      else $error("snoop retry without copy-back");
   AST_GLOBAL: assert property (
      o_bus_req && o_bus_type != `DCCF_BUS_WB && op_reg != `DCCF_OP_FETCH
      |-> o_bus_glb == coh_reg) else $error("global indicator wrong");
   AST_READY_IDLE: assert property (
      o_req_ready |-> !i_snp_valid && !i_flash_inv && !o_bus_req)
      else $error("request ready while busy");
endmodule // dccf_monitor

bind dccf_core dccf_monitor u_mon (.i_ref_clk, .i_rst, .i_four_state_protocol_select,
   .i_flash_inv, .i_req_valid, .i_req_op, .i_req_mem_attr, .i_snp_valid, .i_bus_ack,
   .i_bus_retry, .o_req_ready, .o_done, .o_snp_retry, .o_bus_req, .o_bus_type,
   .o_bus_addr, .o_bus_glb);

// >>> bench/dccf_bus_model.sv
// Bus partner model: memory and other masters on the coherent system bus.
// Assumes the core holds its request and fields until an ack without retry.
`timescale 1ns/1ps

module dccf_bus_model (
   input  wire i_ref_clk,
   input  wire i_rst,
   input  wire i_bus_req,
   input  wire i_share_en,
   input  wire i_retry_en,
   output reg  o_bus_ack,
   output reg  o_bus_retry,
   output reg  o_bus_share
);
   int wait_n = 0;
   bit tried  = 0;

   initial begin
      o_bus_ack   = 1'b0;
      o_bus_retry = 1'b0;
      o_bus_share = 1'b0;
   end

   // Ack a held request after a random wait, never on two cycles in a row
   always @(posedge i_ref_clk) begin
      #1;
      o_bus_ack   = 1'b0;
      o_bus_retry = 1'b0;
      o_bus_share = ~o_bus_share;    // Meaningless outside an ack
      if (i_rst || !i_bus_req) begin
         wait_n = $urandom % 4;
         tried  = 0;
      end else if (wait_n > 0) begin
         wait_n = wait_n - 1;
      end else begin
         o_bus_retry = i_retry_en && !tried;
         tried       = 1;
         o_bus_share = i_share_en;
         o_bus_ack   = 1'b1;
         wait_n      = 1 + $urandom % 4;
      end
   end
endmodule // dccf_bus_model

// >>> bench/dccf_core_tb.sv
// Self-checking bench for the coherency state machine, with a state model.
// Assumes dccf_bus_model as bus partner and the bound port checker.
`timescale 1ns/1ps
`include "dccf_defs.vh"

module dccf_core_tb;
   logic        i_ref_clk = 0, i_rst = 1, i_four_state_protocol_select = 0;
   logic        i_flash_inv = 0, i_req_valid = 0, i_req_xlate_en = 1, i_snp_valid = 0;
   logic [2:0]  i_req_op = 0, i_req_mem_attr = 0, i_snp_type = 0;
   logic [26:0] i_req_addr = 0, i_snp_addr = 0;
   wire         o_req_ready, o_done, o_done_hit, o_snp_ready, o_snp_retry, o_bus_req;
   wire         o_bus_glb, i_bus_ack, i_bus_retry, i_bus_share;
   wire  [1:0]  o_done_state, o_bus_type;
   wire  [26:0] o_bus_addr;
   logic        share_en = 0, retry_en = 0;
   int          num_errors = 0, n_compared = 0, a, b;
   int          st [int];
   int          lru [8][$];
   bit          ic [int];
   logic [29:0] bq [$];

   dccf_core uut (.i_ref_clk, .i_rst, .i_four_state_protocol_select, .i_flash_inv,
      .i_req_valid, .i_req_op, .i_req_addr, .i_req_mem_attr, .i_req_xlate_en, .o_req_ready,
      .o_done, .o_done_hit, .o_done_state, .i_snp_valid, .i_snp_type, .i_snp_addr,
      .o_snp_ready, .o_snp_retry, .o_bus_req, .o_bus_type, .o_bus_addr, .o_bus_glb,
      .i_bus_ack, .i_bus_retry, .i_bus_share);
   dccf_bus_model u_bus (.i_ref_clk, .i_rst, .i_bus_req(o_bus_req), .i_share_en(share_en),
      .i_retry_en(retry_en), .o_bus_ack(i_bus_ack), .o_bus_retry(i_bus_retry),
      .o_bus_share(i_bus_share));

   always #20 i_ref_clk = ~i_ref_clk;

   // Log every finished bus transfer as {glb, type, addr}
   always @(posedge i_ref_clk) begin
      if (o_bus_req && i_bus_ack && !i_bus_retry) bq.push_back({o_bus_glb, o_bus_type, o_bus_addr});
   end

   task automatic chk(string nm, logic [29:0] e, logic [29:0] g);
      n_compared++;
      if (e !== g) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_bus(logic [29:0] eq [$]);
      foreach (eq[i]) chk("bus transfer", eq[i], bq.size() ? bq.pop_front() : 30'h3fff_ffff);
      chk("bus count", 30'h0, 30'(bq.size()));
   endtask

   function automatic int ad(int s);
      return (($urandom % 4096) << 3) | s;
   endfunction

   task automatic touch(int a);
      int q [$];
      q = lru[a % 8].find_index with (item == a);
      if (q.size()) lru[a % 8].delete(q[0]);
      lru[a % 8].push_back(a);
   endtask

   // Core request with expected bus traffic and resulting state
   task automatic req(int op, int a, logic [2:0] at = 3'h1, logic xl = 1);
      int s, v, w;
      logic [1:0] ns;
      logic hit, m;
      logic [29:0] eq [$];
      s = st.exists(a) ? st[a] : 0;
      m = i_four_state_protocol_select;
      hit = 1;
      ns = 2'(s);
      if (op == `DCCF_OP_FETCH) begin
         ns = 0;
         hit = ic.exists(a);
         ic[a] = 1;
         if (!hit) eq.push_back({m ? (at[0] | !xl) : (xl & at[0]), `DCCF_BUS_READ, 27'(a)});
      end else if (op == `DCCF_OP_CLEAN) begin
         hit = s != 0;
         if (s == 3) eq.push_back({at[0], `DCCF_BUS_WB, 27'(a)});
         if (s != 0) ns = m ? 2'h1 : 2'h2;
      end else if (op == `DCCF_OP_STORE ? s > 1 : s != 0) begin
         if (op == `DCCF_OP_STORE) ns = 2'h3;
      end else begin
         hit = 0;
         if (s == 0 && lru[a % 8].size() == 2) begin
            v = lru[a % 8].pop_front();
            if (st[v] == 3) eq.push_back({3'h2, 27'(v)});
            st.delete(v);
         end
         eq.push_back({at[0], (m && (op == `DCCF_OP_LOAD || op == `DCCF_OP_TLOAD)) ?
            `DCCF_BUS_READ : `DCCF_BUS_RDMOD, 27'(a)});
         ns = op == `DCCF_OP_STORE ? 2'h3 : (m && share_en && op != `DCCF_OP_TSTORE) ? 2'h1 : 2'h2;
      end
      i_req_op = 3'(op);
      i_req_addr = 27'(a);
      i_req_mem_attr = at;
      i_req_xlate_en = xl;
      i_req_valid = 1;
      @(posedge i_ref_clk);
      #1 i_req_valid = 0;
      w = 0;
      while (!o_done && w < 300) begin
         @(posedge i_ref_clk);
         #1;
         w++;
      end
      chk("done seen", 30'h1, 30'(o_done));
      chk("done hit", 30'(hit), 30'(o_done_hit));
      chk("done state", 30'(ns), 30'(o_done_state));
      cmp_bus(eq);
      if (op != `DCCF_OP_FETCH) st[a] = ns;
      if (op != `DCCF_OP_FETCH && op != `DCCF_OP_CLEAN) touch(a);
   endtask

   // Snooped transfer with expected retry, copy-back and new state
   task automatic snoop(int t, int a);
      int s;
      logic [1:0] ns;
      logic m, wb;
      logic [29:0] eq [$];
      s = st.exists(a) ? st[a] : 0;
      m = i_four_state_protocol_select;
      wb = s == 3 && t != `DCCF_SNP_KILL;
      ns = (t == `DCCF_SNP_READ1 || t == `DCCF_SNP_CLEAN || (t == `DCCF_SNP_READ && m)) ?
         (m ? 2'h1 : 2'h2) : 2'h0;
      if (s == 0) ns = 0;
      if (wb) eq.push_back({3'h2, 27'(a)});
      i_snp_type = 3'(t);
      i_snp_addr = 27'(a);
      i_snp_valid = 1;
      @(posedge i_ref_clk);
      #1 i_snp_valid = 0;
      i_snp_addr = 27'($urandom);
      chk("snoop retry", 30'(wb), 30'(o_snp_retry));
      @(posedge i_ref_clk);
      #1;
      for (int w = 0; w < 300 && o_bus_req; w++) begin
         @(posedge i_ref_clk);
         #1;
      end
      cmp_bus(eq);
      st[a] = ns;
   endtask

   task automatic flash;
      i_flash_inv = 1;
      @(posedge i_ref_clk);
      #1 i_flash_inv = 0;
      st.delete();
      ic.delete();
      foreach (lru[i]) lru[i].delete();
   endtask

   // Every snoop kind on a modified block, then again on that block after a load of it
   task automatic snp_all;
      int a;
      for (int t = 0; t < 5; t++) begin
         a = ad(7);
         req(`DCCF_OP_STORE, a);
         snoop(t, a);
         req(`DCCF_OP_LOAD, a);
         snoop(t, a);
         flash;
      end
   endtask

   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #800000;
      num_errors++;
      wrap_up;
   end

   initial begin
      void'($urandom(59));
      repeat (4) @(posedge i_ref_clk);
      #1 i_rst = 0;
      a = ad(1);
      req(`DCCF_OP_LOAD, a);
      req(`DCCF_OP_LOAD, a);
      req(`DCCF_OP_STORE, a);
      req(`DCCF_OP_TLOAD, ad(2));
      req(`DCCF_OP_TSTORE, ad(3));
      req(`DCCF_OP_LOAD, ad(4), 3'h0);
      b = ad(0);
      req(`DCCF_OP_STORE, b);
      retry_en = 1;
      req(`DCCF_OP_STORE, b + 8);
      retry_en = 0;
      req(`DCCF_OP_LOAD, b + 16);
      req(`DCCF_OP_CLEAN, b + 8);
      snp_all;
      flash;
      i_four_state_protocol_select = 1;
      share_en = 1;
      a = ad(1);
      req(`DCCF_OP_LOAD, a);
      req(`DCCF_OP_LOAD, a);
      req(`DCCF_OP_STORE, a);
      req(`DCCF_OP_CLEAN, a);
      share_en = 0;
      retry_en = 1;
      req(`DCCF_OP_LOAD, ad(2));
      retry_en = 0;
      req(`DCCF_OP_TLOAD, ad(3));
      req(`DCCF_OP_TSTORE, ad(4));
      a = ad(5);
      req(`DCCF_OP_FETCH, a, 3'h0, 0);
      req(`DCCF_OP_FETCH, a, 3'h0, 0);
      req(`DCCF_OP_FETCH, ad(6), 3'h0, 1);
      snp_all;
      wrap_up;
   end
endmodule // dccf_core_tb
